// file: pkg/bit_logic_consts.vh
// constants for the single-bit carry datapath
`ifndef BIT_LOGIC_CONSTS_VH
`define BIT_LOGIC_CONSTS_VH

// =====================================================================
// operation codes
`define OP_W 4
`define OP_BAND 4'h0
`define OP_AND_INV 4'h1
`define OP_OR 4'h2
`define OP_OR_INV 4'h3
`define OP_XOR 4'h4
`define OP_XOR_INV 4'h5
`define OP_BLOAD 4'h6
`define OP_BILOAD 4'h7
`define OP_BSTORE 4'h8
`define OP_BISTORE 4'h9

// =====================================================================
// operand forms
`define SRC_W 2
`define SRC_REG 2'h0
`define SRC_IND 2'h1
`define SRC_ABS 2'h2

// =====================================================================
// widths and reset values
`define BYTE_W 8
`define IDX_W 3
`define REGSEL_W 4
`define IND_ADDR_W 24
`define ABS_ADDR_W 8
`define FULL_ADDR_W 24
`define ABS_PAGE 16'hFFFF
`define CCR_W 8
`define CCR_C 0
`define CCR_V 1
`define CCR_Z 2
`define CCR_N 3
`define CCR_H 5
`define CCR_I 7
`define CCR_RST 8'h80
`define BYTE_RST 8'h00

`endif

// file: verilog/bit_pick.v
// selects one bit of a byte by a 3-bit index
`timescale 1ns/1ps
`default_nettype none
`include "bit_logic_consts.vh"

module bit_pick #(
  parameter WIDTH = `BYTE_W,
  parameter IW = `IDX_W
) (
  input wire [WIDTH-1:0] data_i,
  input wire [IW-1:0] idx_i,
  output wire bit_o
);

  // index 0 is the least significant bit
  assign bit_o = data_i[idx_i]; // RULE12

endmodule
`default_nettype wire

// file: verilog/bit_insert.v
// replaces one bit of a byte, keeping the others
`timescale 1ns/1ps
`default_nettype none
`include "bit_logic_consts.vh"

module bit_insert #(
  parameter WIDTH = `BYTE_W,
  parameter IW = `IDX_W
) (
  input wire [WIDTH-1:0] data_i,
  input wire [IW-1:0] idx_i,
  input wire bit_i,
  output reg [WIDTH-1:0] data_o
);

  // copy byte, then overwrite the chosen position only
  always @* begin
    data_o = data_i; // RULE3
    data_o[idx_i] = bit_i; // RULE12
  end

endmodule
`default_nettype wire

// file: verilog/bit_logic_carry_unit.v
// single-bit instruction datapath with carry flag and byte operand access
//
// Contract
// RULE1 - load selects operand bit into carry for all three operand forms
// RULE2 - inverted load puts complement of selected bit into carry
// RULE3 - store writes carry into selected bit, other bits unchanged
// RULE4 - inverted store writes complement of carry into selected bit
// RULE5 - AND: carry becomes carry AND selected bit
// RULE6 - inverted AND: carry becomes carry AND complement of bit
// RULE7 - OR: carry becomes carry OR selected bit
// RULE8 - inverted OR: carry becomes carry OR complement of bit
// RULE9 - XOR: carry becomes carry XOR selected bit
// RULE10 - inverted XOR: carry becomes carry XOR complement of bit
// RULE11 - I, H, N, Z, V never change; stores leave carry unchanged
// RULE12 - immediate value 0 selects bit 0, value 7 selects bit 7
`timescale 1ns/1ps
`default_nettype none
`include "bit_logic_consts.vh"

// =====================================================================
// sequencer overview
//   idle: waits for start_i; the instruction fields are captured then
//   register read: the byte on reg_rdata_i is taken in the same cycle as the strobe
//   memory read: the request stands until mem_ack_i, data is taken with it
//   execute: carry update for loads and logic ops, bit merge for stores
//   register write: one strobe back to the register that was read
//   memory write: the merged byte goes to the same address, again until ack
// register forms finish three cycles after issue, register stores four
// memory forms take two cycles plus the read wait, stores the write wait more
// undefined op codes still read the operand, then finish with no change
// start_i while busy is ignored and leaves no trace on any port
// a core write of the flags wins over the carry update in the same cycle

module bit_logic_carry_unit #(
  parameter NREG = 16
) (
  input wire ref_clk_i,
  input wire arst_n_i,
  // instruction issue
  input wire start_i,
  input wire [`OP_W-1:0] op_i,
  input wire [`SRC_W-1:0] src_i,
  input wire [`IDX_W-1:0] bit_idx_i,
  input wire [`REGSEL_W-1:0] byte_general_register_i,
  input wire [`IND_ADDR_W-1:0] register_indirect_24bit_address_i,
  input wire [`ABS_ADDR_W-1:0] short_absolute_address_i,
  output wire busy_o,
  output reg done_o,
  // condition code register load (core writes flags directly)
  input wire ccr_wr_i,
  input wire [`CCR_W-1:0] ccr_wdata_i,
  output reg [`CCR_W-1:0] ccr_o,
  // general register file byte port
  output reg reg_rd_o,
  output reg [`REGSEL_W-1:0] reg_sel_o,
  input wire [`BYTE_W-1:0] reg_rdata_i,
  output reg reg_wr_o,
  output reg [`BYTE_W-1:0] reg_wdata_o,
  // memory byte port
  output reg mem_req_o,
  output reg mem_we_o,
  output reg [`FULL_ADDR_W-1:0] mem_addr_o,
  output reg [`BYTE_W-1:0] mem_wdata_o,
  input wire mem_ack_i,
  input wire [`BYTE_W-1:0] mem_rdata_i
);

  // =====================================================================
  // state encoding
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_REG_RD = 3'h1;
  localparam [2:0] ST_MEM_RD = 3'h2;
  localparam [2:0] ST_EXEC = 3'h3;
  localparam [2:0] ST_REG_WR = 3'h4;
  localparam [2:0] ST_MEM_WR = 3'h5;

  reg [2:0] state;
  reg [2:0] next_state;
  reg [`OP_W-1:0] op;
  reg [`SRC_W-1:0] src;
  reg [`IDX_W-1:0] idx;
  reg [`BYTE_W-1:0] operand;
  reg [`FULL_ADDR_W-1:0] addr;
  wire sel_bit;
  wire [`BYTE_W-1:0] merged;
  reg new_carry;
  reg store_bit;
  wire is_store;
  wire carry;
  wire take;
  wire [`FULL_ADDR_W-1:0] issue_addr;
  wire store_reg;
  wire store_mem;

  assign carry = ccr_o[`CCR_C];
  assign is_store = (op == `OP_BSTORE) || (op == `OP_BISTORE);
  assign busy_o = (state != ST_IDLE);

  // an instruction is taken only while the sequencer is idle
  assign take = (state == ST_IDLE) && start_i;
  // short absolute addresses sit in the top page of the 24-bit space
  assign issue_addr = (src_i == `SRC_IND) ? register_indirect_24bit_address_i
                                          : {`ABS_PAGE, short_absolute_address_i};

  // write-back target of a store, decided in the execute cycle
  assign store_reg = (state == ST_EXEC) && is_store && (src == `SRC_REG);
  assign store_mem = (state == ST_EXEC) && is_store && (src != `SRC_REG);

  // =====================================================================
  // bit selection and insertion
  // operand bit chosen by the captured index
  bit_pick #(
    .WIDTH(`BYTE_W),
    .IW(`IDX_W)
  ) u_pick (
    .data_i(operand),
    .idx_i(idx),
    .bit_o(sel_bit)
  );

  // store byte: the operand with the chosen bit replaced
  bit_insert #(
    .WIDTH(`BYTE_W),
    .IW(`IDX_W)
  ) u_insert (
    .data_i(operand),
    .idx_i(idx),
    .bit_i(store_bit),
    .data_o(merged)
  );

  // =====================================================================
  // carry and store-bit computation
  always @* begin
    new_carry = carry;
    store_bit = carry;
    case (op)
      `OP_BLOAD: new_carry = sel_bit; // RULE1
      `OP_BILOAD: new_carry = ~sel_bit; // RULE2
      `OP_BAND: new_carry = carry & sel_bit; // RULE5
      `OP_AND_INV: new_carry = carry & ~sel_bit; // RULE6
      `OP_OR: new_carry = carry | sel_bit; // RULE7
      `OP_OR_INV: new_carry = carry | ~sel_bit; // RULE8
      `OP_XOR: new_carry = carry ^ sel_bit; // RULE9
      `OP_XOR_INV: new_carry = carry ^ ~sel_bit; // RULE10
      `OP_BSTORE: store_bit = carry; // RULE3
      `OP_BISTORE: store_bit = ~carry; // RULE4
      default: new_carry = carry;
    endcase
  end

  // =====================================================================
  // sequencer next state
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (start_i) begin
          if (src_i == `SRC_REG) begin
            next_state = ST_REG_RD;
          end else begin
            next_state = ST_MEM_RD;
          end
        end
      end
      ST_REG_RD: next_state = ST_EXEC;
      ST_MEM_RD: begin
        if (mem_ack_i) begin
          next_state = ST_EXEC;
        end
      end
      ST_EXEC: begin
        if (!is_store) begin
          next_state = ST_IDLE;
        end else if (src == `SRC_REG) begin
          next_state = ST_REG_WR;
        end else begin
          next_state = ST_MEM_WR;
        end
      end
      ST_REG_WR: next_state = ST_IDLE;
      ST_MEM_WR: begin
        if (mem_ack_i) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // =====================================================================
  // sequencer state register
  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // =====================================================================
  // instruction capture: fields are held for the whole instruction
  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      op <= `OP_BLOAD;
      src <= `SRC_REG;
      idx <= {`IDX_W{1'b0}};
      addr <= {`FULL_ADDR_W{1'b0}};
    end else if (take) begin
      op <= op_i;
      src <= src_i;
      idx <= bit_idx_i; // RULE12
      addr <= issue_addr; // RULE1
    end
  end

  // =====================================================================
  // operand byte capture
  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      operand <= `BYTE_RST;
    end else if (state == ST_REG_RD) begin
      operand <= reg_rdata_i;
    end else if (state == ST_MEM_RD && mem_ack_i) begin
      operand <= mem_rdata_i;
    end
  end

  // =====================================================================
  // condition codes: the core write loads all flags, instructions change only carry
  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ccr_o <= `CCR_RST;
    end else if (ccr_wr_i) begin
      ccr_o <= ccr_wdata_i;
    end else if (state == ST_EXEC && !is_store) begin
      ccr_o[`CCR_C] <= new_carry; // RULE11
    end
  end

  // =====================================================================
  // register file byte port: read strobe at issue, write strobe for stores
  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reg_rd_o <= 1'b0;
      reg_sel_o <= {`REGSEL_W{1'b0}};
      reg_wr_o <= 1'b0;
      reg_wdata_o <= `BYTE_RST;
    end else begin
      // strobes are one-cycle pulses
      reg_rd_o <= 1'b0;
      reg_wr_o <= 1'b0;
      if (take && src_i == `SRC_REG) begin
        reg_rd_o <= 1'b1; // RULE1
        reg_sel_o <= byte_general_register_i;
      end
      // the write goes back to the register that was read
      if (store_reg) begin
        reg_wr_o <= 1'b1; // RULE3
        reg_wdata_o <= merged; // RULE4
      end
    end
  end

  // =====================================================================
  // memory byte port: the request stands until its acknowledge
  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mem_req_o <= 1'b0;
      mem_we_o <= 1'b0;
      mem_addr_o <= {`FULL_ADDR_W{1'b0}};
      mem_wdata_o <= `BYTE_RST;
    end else if (take && src_i != `SRC_REG) begin
      // operand read
      mem_req_o <= 1'b1;
      mem_we_o <= 1'b0;
      mem_addr_o <= issue_addr; // RULE1
    end else if (store_mem) begin
      // write-back of the merged byte to the same address
      mem_req_o <= 1'b1;
      mem_we_o <= 1'b1;
      mem_addr_o <= addr;
      mem_wdata_o <= merged; // RULE4
    end else if ((state == ST_MEM_RD || state == ST_MEM_WR) && mem_ack_i) begin
      mem_req_o <= 1'b0;
      mem_we_o <= 1'b0;
    end
  end

  // =====================================================================
  // completion pulse: after execute for loads and logic ops, after the write for stores
  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      done_o <= 1'b0;
    end else if (state == ST_EXEC && !is_store) begin
      done_o <= 1'b1;
    end else if (state == ST_REG_WR || (state == ST_MEM_WR && mem_ack_i)) begin
      done_o <= 1'b1;
    end else begin
      done_o <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// file: verification/bit_logic_carry_unit_sva.sv
// assertions on the single-bit carry datapath ports
`timescale 1ns/1ps
`default_nettype none
`include "bit_logic_consts.vh"
// =====
// checker
module bit_logic_carry_unit_sva (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic start_i,
  input wire logic [`OP_W-1:0] op_i,
  input wire logic [`SRC_W-1:0] src_i,
  input wire logic busy_o,
  input wire logic done_o,
  input wire logic ccr_wr_i,
  input wire logic [`CCR_W-1:0] ccr_o,
  input wire logic reg_rd_o,
  input wire logic reg_wr_o,
  input wire logic mem_req_o,
  input wire logic mem_we_o,
  input wire logic [`FULL_ADDR_W-1:0] mem_addr_o,
  input wire logic mem_ack_i
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);
  // register-form issue taken by the sequencer
  sequence s_issue(logic sel);
    start_i && !busy_o && src_i == `SRC_REG && sel;
  endsequence
  // write strobe then completion
  sequence s_store_tail;
    reg_wr_o ##1 done_o;
  endsequence
  chk_flags_kept: assert property (!$past(ccr_wr_i) |-> ccr_o[7:1] == $past(ccr_o[7:1]))
    else $error("upper flags changed");
  chk_store_keeps_c: assert property (done_o && op_i >= `OP_BSTORE && !$past(ccr_wr_i) |-> $stable(ccr_o[0]))
    else $error("store changed carry");
  chk_reg_latency: assert property (s_issue(op_i < `OP_BSTORE) |-> ##3 done_o)
    else $error("register op done late");
  chk_reg_store: assert property (s_issue(op_i == `OP_BSTORE || op_i == `OP_BISTORE) |-> ##3 s_store_tail)
    else $error("register store sequence wrong");
  chk_read_issue: assert property (s_issue(1'b1) |=> reg_rd_o)
    else $error("no register read");
  chk_req_hold: assert property (mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o) && $stable(mem_we_o))
    else $error("memory request dropped");
  chk_write_only_store: assert property (reg_wr_o || (mem_req_o && mem_we_o) |-> op_i inside {`OP_BSTORE, `OP_BISTORE})
    else $error("write outside store");
  chk_idle_quiet: assert property (!busy_o |-> !reg_rd_o && !mem_req_o && !reg_wr_o)
    else $error("strobe while idle");
endmodule
`default_nettype wire

// file: verification/bit_logic_carry_unit_tb.sv
// self-checking bench for the single-bit carry datapath
`timescale 1ns/1ps
`default_nettype none
`include "bit_logic_consts.vh"
`define CHK(n, e, s) begin checks_done++; if ((e) !== (s)) begin fails++; $display("mismatch %s exp %h got %h", n, e, s); end end
// =====
// bench
module bit_logic_carry_unit_tb;
  logic ref_clk_i = 0, arst_n_i = 0, start_i = 0, ccr_wr_i = 0, mem_ack_i = 0;
  logic [3:0] op_i = 0, byte_general_register_i = 0, reg_sel_o;
  logic [1:0] src_i = 0;
  logic [2:0] bit_idx_i = 0;
  logic [23:0] register_indirect_24bit_address_i = 0, mem_addr_o, aseen;
  logic [7:0] short_absolute_address_i = 0, ccr_wdata_i = 0, reg_rdata_i = 0, mem_rdata_i = 0, rb = 0, wseen;
  logic [7:0] ccr_o, reg_wdata_o, mem_wdata_o;
  logic busy_o, done_o, reg_rd_o, reg_wr_o, mem_req_o, mem_we_o;
  int fails = 0, checks_done = 0, cyc = 0;
  logic [23:0] ea_hold = 0;
  logic [7:0] e_hold = 0;
  bit_logic_carry_unit DUT (.ref_clk_i, .arst_n_i, .start_i, .op_i, .src_i, .bit_idx_i, .byte_general_register_i,
    .register_indirect_24bit_address_i, .short_absolute_address_i, .busy_o, .done_o, .ccr_wr_i, .ccr_wdata_i,
    .ccr_o, .reg_rd_o, .reg_sel_o, .reg_rdata_i, .reg_wr_o, .reg_wdata_o, .mem_req_o, .mem_we_o, .mem_addr_o,
    .mem_wdata_o, .mem_ack_i, .mem_rdata_i);
  always #12.5 ref_clk_i = ~ref_clk_i;
  // register and memory responder with random memory wait
  always @(posedge ref_clk_i) begin
    mem_ack_i <= 1'h0;
    mem_rdata_i <= ~rb;
    // seen values start inverted at each issue so a missing transfer shows
    if (start_i) begin
      aseen <= ~ea_hold;
      wseen <= ~e_hold;
    end
    if (reg_rd_o) aseen <= {20'h0, reg_sel_o};
    if (reg_wr_o) begin
      wseen <= reg_wdata_o;
      aseen <= {20'h0, reg_sel_o};
    end
    if (mem_req_o && !mem_ack_i && $urandom_range(2) == 0) begin
      mem_ack_i <= 1'h1;
      mem_rdata_i <= rb;
      aseen <= mem_addr_o;
      if (mem_we_o) wseen <= mem_wdata_o;
    end
  end
  // expected carry
  function automatic logic ec(input logic [3:0] op, input logic c, input logic b);
    case (op)
      `OP_BAND: ec = c & b;
      `OP_AND_INV: ec = c & ~b;
      `OP_OR: ec = c | b;
      `OP_OR_INV: ec = c | ~b;
      `OP_XOR: ec = c ^ b;
      `OP_XOR_INV: ec = c ^ ~b;
      `OP_BLOAD: ec = b;
      `OP_BILOAD: ec = ~b;
      default: ec = c;
    endcase
  endfunction
  // one instruction: load flags, issue, wait, compare
  task automatic run(input logic [3:0] op, input logic [1:0] sr, input logic [2:0] ix);
    logic [7:0] w, x, e;
    logic [23:0] a, ea;
    logic st;
    int n;
    w = $urandom;
    x = $urandom;
    a = $urandom;
    st = op == `OP_BSTORE || op == `OP_BISTORE;
    e = x;
    if (st) e[ix] = w[0] ^ (op == `OP_BISTORE);
    ea = sr == `SRC_REG ? {20'h0, a[3:0]} : sr == `SRC_IND ? a : {`ABS_PAGE, a[7:0]};
    e_hold = e;
    ea_hold = ea;
    @(posedge ref_clk_i);
    rb <= x;
    reg_rdata_i <= x;
    ccr_wr_i <= 1'h1;
    ccr_wdata_i <= w;
    @(posedge ref_clk_i);
    ccr_wr_i <= 1'h0;
    start_i <= 1'h1;
    op_i <= op;
    src_i <= sr;
    bit_idx_i <= ix;
    byte_general_register_i <= a[3:0];
    register_indirect_24bit_address_i <= a;
    short_absolute_address_i <= a[7:0];
    @(posedge ref_clk_i);
    start_i <= 1'h0;
    n = 0;
    while (done_o !== 1'h1 && n < 40) begin
      @(negedge ref_clk_i);
      n++;
    end
    `CHK("done", 1'h1, done_o)
    `CHK("busy", 1'h0, busy_o)
    `CHK("carry", ec(op, w[0], x[ix]), ccr_o[0])
    `CHK("flags", w[7:1], ccr_o[7:1])
    `CHK("byte", st ? e : ~e, wseen)
    `CHK("addr", ea, aseen)
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // hang guard
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      summarize();
    end
  end
  // every op code and form at both end bits, then random traffic
  initial begin
    void'($urandom(66));
    repeat (12) @(posedge ref_clk_i);
    arst_n_i <= 1'h1;
    @(negedge ref_clk_i);
    `CHK("reset ccr", `CCR_RST, ccr_o)
    for (int o = 0; o < 16; o++) begin
      for (int s = 0; s < 3; s++) begin
        run(4'(o), 2'(s), 3'h0);
        run(4'(o), 2'(s), 3'h7);
      end
    end
    // reset again in mid-run: flags and outputs return to their reset values
    @(posedge ref_clk_i);
    arst_n_i <= 1'h0;
    repeat (2) @(posedge ref_clk_i);
    arst_n_i <= 1'h1;
    @(negedge ref_clk_i);
    `CHK("reset ccr", `CCR_RST, ccr_o)
    `CHK("reset busy", 1'h0, busy_o)
    `CHK("reset req", 1'h0, mem_req_o)
    repeat (200) run(4'($urandom_range(9)), 2'($urandom_range(2)), 3'($urandom));
    summarize();
  end
endmodule
bind bit_logic_carry_unit bit_logic_carry_unit_sva chk_i (.ref_clk_i, .arst_n_i, .start_i, .op_i, .src_i, .busy_o,
  .done_o, .ccr_wr_i, .ccr_o, .reg_rd_o, .reg_wr_o, .mem_req_o, .mem_we_o, .mem_addr_o, .mem_ack_i);
`default_nettype wire
